// *** common/keypad_pkg.sv ***
// Purpose: constants and types for the keypad interrupt unit
// Assumes: 32-bit AXI4-Lite register access, one word per register
// Notes:   reset values are zero throughout

package keypad_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int unsigned PIN_COUNT  = 8;
  localparam int unsigned ADDR_WIDTH = 4;
  localparam int unsigned DATA_WIDTH = 32;
  localparam int unsigned SYNC_DEPTH = 2;

  // ----------------------------------------------------------------
  // register byte addresses
  // ----------------------------------------------------------------
  localparam logic [3:0] STATUS_CONTROL_ADDR = 4'h0;
  localparam logic [3:0] PIN_ENABLE_ADDR     = 4'h4;
  localparam logic [3:0] IRQ_STATUS_ADDR     = 4'h8;
  localparam logic [3:0] IRQ_MASK_ADDR       = 4'hc;

  // ----------------------------------------------------------------
  // status/control field positions
  // ----------------------------------------------------------------
  localparam int unsigned MODE_BIT  = 0;
  localparam int unsigned IRQEN_BIT = 1;
  localparam int unsigned CLEAR_BIT = 2;
  localparam int unsigned FLAG_BIT  = 3;
  localparam int unsigned POL_LSB   = 4;
  localparam int unsigned POL_WIDTH = 4;

  // irq status / mask bit positions
  localparam int unsigned EV_TRIGGER = 0;
  localparam int unsigned EV_WAKE    = 1;
  localparam int unsigned EV_COUNT   = 2;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [3:0] POL_RESET    = 4'h0;
  localparam logic [7:0] ENABLE_RESET = 8'h00;
  localparam logic [1:0] EV_RESET     = 2'h0;

  // ----------------------------------------------------------------
  // bus responses
  // ----------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // software-visible control fields of the status/control register
  typedef struct packed {
    logic [3:0] trigger_polarity_select;
    logic       key_irq_enable;
    logic       detect_mode_select;
  } control_s;

endpackage

// *** rtl/keyboard_edge_level_interrupt.sv ***
// Purpose: keypad interrupt unit, eight pins, edge or edge+level
// Assumes: pins may change at any time; stop_mode from power control
//          stop_mode high means the bus clock is about to stop
// Notes:   registers over AXI4-Lite, irq is a level output
//          wake_request is raw and asynchronous, valid only in stop
//          the flag and the event bits favour a set over a clear

`timescale 1ns/100ps
`default_nettype none

module keyboard_edge_level_interrupt (
  input  wire logic                               clock,
  input  wire logic                               rst_n,
  input  wire logic [keypad_pkg::ADDR_WIDTH-1:0]  s_axi_awaddr,
  input  wire logic                               s_axi_awvalid,
  output logic                                    s_axi_awready,
  input  wire logic [keypad_pkg::DATA_WIDTH-1:0]  s_axi_wdata,
  input  wire logic [3:0]                         s_axi_wstrb,
  input  wire logic                               s_axi_wvalid,
  output logic                                    s_axi_wready,
  output logic [1:0]                              s_axi_bresp,
  output logic                                    s_axi_bvalid,
  input  wire logic                               s_axi_bready,
  input  wire logic [keypad_pkg::ADDR_WIDTH-1:0]  s_axi_araddr,
  input  wire logic                               s_axi_arvalid,
  output logic                                    s_axi_arready,
  output logic [keypad_pkg::DATA_WIDTH-1:0]       s_axi_rdata,
  output logic [1:0]                              s_axi_rresp,
  output logic                                    s_axi_rvalid,
  input  wire logic                               s_axi_rready,
  input  wire logic [keypad_pkg::PIN_COUNT-1:0]   key_pin,
  input  wire logic                               stop_mode,
  output logic [keypad_pkg::PIN_COUNT-1:0]        pin_force_input,
  output logic                                    wake_request,
  output logic                                    irq
);

  // short name for the pin count, used all through the pin logic
  localparam int unsigned N = keypad_pkg::PIN_COUNT;

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  // control fields in one struct; the flag is kept apart as it
  // is set by hardware, not written by software
  keypad_pkg::control_s                  control;
  logic [N-1:0]                          key_pin_enable;
  logic                                  key_event_flag;
  logic [keypad_pkg::EV_COUNT-1:0]       irq_status;
  logic [keypad_pkg::EV_COUNT-1:0]       irq_mask;

  // ----------------------------------------------------------------
  // pin front end
  // ----------------------------------------------------------------
  // sync_b is the settled sample; was_deasserted arms each pin
  logic [N-1:0] sync_a;
  logic [N-1:0] sync_b;
  logic [N-1:0] pin_polarity;
  logic [N-1:0] asserted;
  logic [N-1:0] was_deasserted;
  logic [N-1:0] edge_seen;
  logic [N-1:0] next_was_deasserted;

  // per-pin polarity, arming and edge detection; one copy per pin
  // keeps the lower and upper pins on identical timing
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_pin
      if (g < keypad_pkg::POL_LSB) begin : g_fixed
        assign pin_polarity[g] = 1'b0;
      end else begin : g_sel
        assign pin_polarity[g] =
          control.trigger_polarity_select[g - keypad_pkg::POL_LSB];
      end
      // asserted means the active level after polarity
      assign asserted[g] = sync_b[g] ~^ pin_polarity[g];
      // only a pin seen deasserted can arm
      assign next_was_deasserted[g] = key_pin_enable[g] & ~asserted[g];
      assign edge_seen[g] = key_pin_enable[g] & asserted[g]
                            & was_deasserted[g];
    end
  endgenerate

  // the first stage may go metastable on a pin edge; only the
  // second stage is read, so a full cycle lets it settle; both
  // reset low, harmless because the enables also reset to zero
  // first stage feeds the second only
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sync_a <= '0;
      sync_b <= '0;
    end else begin
      sync_a <= key_pin;
      sync_b <= sync_a;
    end
  end

  // previous sample history; reset leaves pins unarmed
  // a pin enabled while asserted stays unarmed until released
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      was_deasserted <= '0;
    end else begin
      was_deasserted <= next_was_deasserted;
    end
  end

  // ----------------------------------------------------------------
  // trigger decision
  // ----------------------------------------------------------------
  // any edge also sets the level hold in level mode, so others_quiet
  // only shapes the edge term; the level hold covers the rest
  wire [N-1:0] enabled_asserted = key_pin_enable & asserted;
  wire         any_edge         = |edge_seen;
  wire         others_quiet     = ~|(enabled_asserted & ~edge_seen);
  wire         level_mode       = control.detect_mode_select;

  // level mode wants the other pins quiet
  wire edge_trigger = any_edge & (~level_mode | others_quiet);

  // level mode holds the flag while asserted
  wire level_hold = level_mode & (|enabled_asserted);

  // stop also blocks the level hold; the wake path takes over
  // clocks gone in stop: no edge logic
  wire trigger_event = ~stop_mode & (edge_trigger | level_hold);

  // ----------------------------------------------------------------
  // wake path
  // ----------------------------------------------------------------
  // limitation: wake_request is combinational from the pins and can
  // glitch; the power controller must treat it as a level
  // raw pin path so wake works without clock
  // raw wake stays falling/low on lower pins
  wire [N-1:0] raw_asserted = key_pin ~^ pin_polarity;
  assign wake_request = stop_mode & (|(key_pin_enable & raw_asserted));

  assign pin_force_input = key_pin_enable;

  // ----------------------------------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------------------------------
  logic                               aw_held;
  logic                               w_held;
  logic [keypad_pkg::ADDR_WIDTH-1:0]  aw_addr;
  logic [keypad_pkg::DATA_WIDTH-1:0]  w_data;
  logic                               w_lane0;

  // address and data may arrive in either order; the write commits
  // one cycle after both are held, and bvalid then blocks new beats
  // until the response is taken
  assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_held & ~s_axi_bvalid;

  wire aw_fire  = s_axi_awvalid & s_axi_awready;
  wire w_fire   = s_axi_wvalid & s_axi_wready;
  wire do_write = aw_held & w_held & ~s_axi_bvalid;
  wire wr_byte  = do_write & w_lane0;

  // write address decode
  wire wr_ctrl = wr_byte & (aw_addr == keypad_pkg::STATUS_CONTROL_ADDR);
  wire wr_en   = wr_byte & (aw_addr == keypad_pkg::PIN_ENABLE_ADDR);
  wire wr_ist  = wr_byte & (aw_addr == keypad_pkg::IRQ_STATUS_ADDR);
  wire wr_msk  = wr_byte & (aw_addr == keypad_pkg::IRQ_MASK_ADDR);
  // wr_hit ignores the strobe, so a lane-masked write answers OKAY
  wire wr_hit  = (aw_addr == keypad_pkg::STATUS_CONTROL_ADDR)
               | (aw_addr == keypad_pkg::PIN_ENABLE_ADDR)
               | (aw_addr == keypad_pkg::IRQ_STATUS_ADDR)
               | (aw_addr == keypad_pkg::IRQ_MASK_ADDR);

  // capture of address and data beats
  // w_lane0 keeps strobe bit 0; the registers fit in one byte
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= '0;
      w_data  <= '0;
      w_lane0 <= 1'b0;
    end else begin
      if (aw_fire) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (do_write) begin
        aw_held <= 1'b0;
      end
      if (w_fire) begin
        w_held  <= 1'b1;
        w_data  <= s_axi_wdata;
        w_lane0 <= s_axi_wstrb[0];
      end else if (do_write) begin
        w_held  <= 1'b0;
      end
    end
  end

  // write response; unmapped addresses answer with an error
  // bresp only means something while bvalid is high
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= keypad_pkg::RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? keypad_pkg::RESP_OKAY
                             : keypad_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // control and enable registers
  // ----------------------------------------------------------------
  // only byte lane 0 carries the eight-bit registers
  // flag and clear bits of the written byte are not stored here
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      control.trigger_polarity_select <= keypad_pkg::POL_RESET;
      control.key_irq_enable          <= 1'b0;
      control.detect_mode_select      <= 1'b0;
    end else if (wr_ctrl) begin
      control.trigger_polarity_select <=
        w_data[keypad_pkg::POL_LSB +: keypad_pkg::POL_WIDTH];
      control.key_irq_enable     <= w_data[keypad_pkg::IRQEN_BIT];
      control.detect_mode_select <= w_data[keypad_pkg::MODE_BIT];
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      key_pin_enable <= keypad_pkg::ENABLE_RESET;
    end else if (wr_en) begin
      key_pin_enable <= w_data[N-1:0];
    end
  end

  // ----------------------------------------------------------------
  // event flag
  // ----------------------------------------------------------------
  // in level mode outside stop the hold term re-sets the flag every cycle, so a
  // clear write has no effect while an enabled pin stays asserted
  // one on the clear bit drops the flag
  wire key_event_clear = wr_ctrl & w_data[keypad_pkg::CLEAR_BIT];

  // set wins over clear, so a late event stays
  // held level re-sets it every cycle
  wire next_key_event_flag = trigger_event
                           | (key_event_flag & ~key_event_clear);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      key_event_flag <= 1'b0;
    end else begin
      key_event_flag <= next_key_event_flag;
    end
  end

  // ----------------------------------------------------------------
  // sticky irq status and mask
  // ----------------------------------------------------------------
  // event bits by position: trigger and wake
  wire [keypad_pkg::EV_COUNT-1:0] ev_pulse;
  assign ev_pulse[keypad_pkg::EV_TRIGGER] = trigger_event;
  assign ev_pulse[keypad_pkg::EV_WAKE]    = wake_request;
  wire [keypad_pkg::EV_COUNT-1:0] ev_clear =
    wr_ist ? w_data[keypad_pkg::EV_COUNT-1:0] : keypad_pkg::EV_RESET;

  // write one clears; a new event in the same cycle stays
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      irq_status <= keypad_pkg::EV_RESET;
    end else begin
      irq_status <= ev_pulse | (irq_status & ~ev_clear);
    end
  end

  // mask bits share the layout of the status bits
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      irq_mask <= keypad_pkg::EV_RESET;
    end else if (wr_msk) begin
      irq_mask <= w_data[keypad_pkg::EV_COUNT-1:0];
    end
  end

  // ----------------------------------------------------------------
  // interrupt output
  // ----------------------------------------------------------------
  // request follows flag only when enabled
  wire flag_request  = control.key_irq_enable & key_event_flag;
  wire event_request = |(irq_status & irq_mask);
  assign irq = flag_request | event_request;

  // ----------------------------------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------------------------------
  // clear bit always reads as zero
  wire [7:0] ctrl_view;
  assign ctrl_view[keypad_pkg::MODE_BIT]  = control.detect_mode_select;
  assign ctrl_view[keypad_pkg::IRQEN_BIT] = control.key_irq_enable;
  assign ctrl_view[keypad_pkg::CLEAR_BIT] = 1'b0;
  assign ctrl_view[keypad_pkg::FLAG_BIT]  = key_event_flag;
  assign ctrl_view[keypad_pkg::POL_LSB +: keypad_pkg::POL_WIDTH] =
    control.trigger_polarity_select;

  // read address decode, combinational on araddr
  wire rd_ctrl = s_axi_araddr == keypad_pkg::STATUS_CONTROL_ADDR;
  wire rd_en   = s_axi_araddr == keypad_pkg::PIN_ENABLE_ADDR;
  wire rd_ist  = s_axi_araddr == keypad_pkg::IRQ_STATUS_ADDR;
  wire rd_msk  = s_axi_araddr == keypad_pkg::IRQ_MASK_ADDR;
  wire rd_hit  = rd_ctrl | rd_en | rd_ist | rd_msk;

  // unmapped addresses read as zero and answer with SLVERR
  wire [keypad_pkg::DATA_WIDTH-1:0] rd_word =
      rd_ctrl ? {24'h00_0000, ctrl_view}
    : rd_en   ? {24'h00_0000, key_pin_enable}
    : rd_ist  ? {30'h0000_0000, irq_status}
    : rd_msk  ? {30'h0000_0000, irq_mask}
    :           32'h0000_0000;

  // one read at a time; arready drops while data waits
  assign s_axi_arready = ~s_axi_rvalid;
  wire ar_fire = s_axi_arvalid & s_axi_arready;

  // rdata is captured at acceptance and held until rready
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= keypad_pkg::RESP_OKAY;
    end else if (ar_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
      s_axi_rresp  <= rd_hit ? keypad_pkg::RESP_OKAY
                             : keypad_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // software duty: flag cleared before stop
  // nothing here enforces it; a flag left set keeps irq high while key_irq_enable is set

endmodule

`default_nettype wire

// *** verification/keypad_chk.sv ***
// Purpose: port-level checks on the keypad interrupt unit
// Assumes: one clock domain, asynchronous active-low reset
// Notes:   flag state is internal, so checks lean on wake and irq
`timescale 1ns/100ps
`default_nettype none
module keypad_chk (
  input wire logic        clock,
  input wire logic        rst_n,
  input wire logic [7:0]  key_pin,
  input wire logic        stop_mode,
  input wire logic [7:0]  pin_force_input,
  input wire logic        wake_request,
  input wire logic        irq,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);

  // wake path only exists while clocks are stopped
  AST_WAKE_STOP: assert property (wake_request |-> stop_mode)
    else $error("wake request outside stop");
  AST_WAKE_LOW0: assert property (
    stop_mode && pin_force_input[0] && !key_pin[0] |-> wake_request)
    else $error("low enabled pin0 gave no wake");
  AST_WAKE_NONE: assert property (
    stop_mode && pin_force_input == 8'h00 |-> !wake_request)
    else $error("wake with no pin enabled");
  AST_WAKE_IDLE: assert property (
    stop_mode && pin_force_input[7:4] == 4'h0
    && &(key_pin[3:0] | ~pin_force_input[3:0]) |-> !wake_request)
    else $error("wake from idle lower pins");
  // polarity: one level of pin4 wakes, the other does not
  AST_WAKE_POL4: assert property (
    stop_mode && $past(stop_mode) && pin_force_input == 8'h10
    && $stable(pin_force_input) && !s_axi_bvalid
    && $changed(key_pin[4]) |-> $changed(wake_request))
    else $error("pin4 level change ignored in stop");
  // clear bit never reads back set
  AST_CLR_READ: assert property (s_axi_rvalid |-> !s_axi_rdata[2])
    else $error("clear bit read back as one");
  // enables only move on a committed write
  AST_FORCE_WR: assert property (
    !$stable(pin_force_input) |-> $rose(s_axi_bvalid))
    else $error("pin force changed without a write");
  // with no pin enabled no event can raise irq
  AST_NOPIN_IRQ: assert property (
    !irq && !s_axi_bvalid && pin_force_input == 8'h00
    && $past(pin_force_input) == 8'h00 |=> !irq || s_axi_bvalid)
    else $error("irq rose with all pins disabled");
endmodule
`default_nettype wire

// *** verification/key_source.sv ***
// Purpose: key switch model driving the keypad pins
// Assumes: the bench sets the level each pin should settle to
// Notes:   slow contacts lag more than one clock period
`timescale 1ns/100ps
`default_nettype none
module key_source (
  input  wire logic [7:0] level,
  input  wire logic       slow,
  output var logic [7:0]  key_pin
);
  initial key_pin = 8'hff;
  // contacts settle off the clock edge, 3 ns after it (13 ns lag when slow)
  always @(level) begin
    key_pin <= #(slow ? 13 : 3) level;
  end
endmodule
`default_nettype wire

// *** verification/tb_top.sv ***
// Purpose: self-checking bench for the keypad interrupt unit
// Assumes: pins from key_source, registers over AXI4-Lite
// Notes:   flag state is read back over the bus
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic        clock = 1'b0;
  logic        rst_n = 1'b0;
  logic        stop_mode = 1'b0;
  logic        slow = 1'b0;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  logic [3:0]  awaddr = 4'h0;
  logic [3:0]  araddr = 4'h0;
  logic [3:0]  wstrb = 4'hf;
  logic [31:0] wdata = 32'h0000_0000;
  logic [7:0]  level = 8'hff;
  logic        awready, wready, bvalid, arready, rvalid, wake_request, irq;
  logic [1:0]  bresp, rresp, last_resp;
  logic [31:0] rdata, d, e;
  logic [7:0]  key_pin, pin_force_input;
  logic [3:0]  pol;
  int          fails = 0;
  int          comparisons = 0;
  int          cycles = 0;

  keyboard_edge_level_interrupt DUT (
    .clock(clock), .rst_n(rst_n), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .key_pin(key_pin), .stop_mode(stop_mode),
    .pin_force_input(pin_force_input), .wake_request(wake_request),
    .irq(irq));
  key_source keys (.level(level), .slow(slow), .key_pin(key_pin));

  always #5 clock = ~clock;

  // watchdog, a hung handshake ends the run as a failure
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      end_sim();
    end
  end

  task automatic end_sim;
    $display("fails %0d comparisons %0d", fails, comparisons);
    if (fails == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // address and data offered together, each dropped once taken
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clock);
    awaddr <= a;
    wdata <= {24'h0000_00, v};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clock);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    last_resp = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clock);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    v = rdata;
    last_resp = rresp;
    rready <= 1'b0;
  endtask

  task automatic flag_is(input logic x);
    rd(keypad_pkg::STATUS_CONTROL_ADDR, e);
    chk({31'h0, e[3]}, {31'h0, x});
  endtask

  task automatic wctl(input logic [7:0] v);
    wr(keypad_pkg::STATUS_CONTROL_ADDR, v);
  endtask

  task automatic wpe(input logic [7:0] v);
    wr(keypad_pkg::PIN_ENABLE_ADDR, v);
  endtask

  // deasserted levels: low pins idle high, upper pins per polarity
  function automatic logic [7:0] idle(input logic [3:0] pl);
    return {~pl, 4'hf};
  endfunction

  initial begin
    void'($urandom(32'h49d8_447c));
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    // reset values, then an address with no register
    for (int i = 0; i < 4; i++) begin
      rd(4'(i * 4), d);
      chk(d, 32'h0000_0000);
    end
    rd(4'h2, d);
    chk({30'h0, last_resp}, {30'h0, keypad_pkg::RESP_SLVERR});
    // unmapped write and a write without lane 0 are both dropped
    wr(4'h2, 8'hff);
    chk({30'h0, last_resp}, {30'h0, keypad_pkg::RESP_SLVERR});
    wstrb <= 4'he;
    wpe(8'hff);
    wstrb <= 4'hf;
    chk({30'h0, last_resp}, {30'h0, keypad_pkg::RESP_OKAY});
    chk({24'h00_0000, pin_force_input}, 32'h0000_0000);
    // random enables read back and force pins to input
    d = $urandom;
    wpe(d[7:0]);
    chk({24'h0000_00, pin_force_input}, {24'h0000_00, d[7:0]});
    rd(keypad_pkg::PIN_ENABLE_ADDR, e);
    chk(e, {24'h0000_00, d[7:0]});
    wpe(8'h00);
    // random control word, clear and flag bits read zero
    d = $urandom | 32'h0000_000c;
    wctl(d[7:0]);
    rd(keypad_pkg::STATUS_CONTROL_ADDR, e);
    chk(e, {24'h0000_00, d[7:0] & 8'hf3});
    // each pin: asserted at enable, wrong edge, right edge, clear
    for (int p = 0; p < 8; p++) begin
      pol = 4'($urandom);
      slow <= p[0];
      level <= idle(pol) ^ (8'h01 << p);
      wctl({pol, 4'h2});
      wpe(8'h01 << p);
      repeat (6) @(posedge clock);
      flag_is(1'b0);
      level <= idle(pol);
      repeat (6) @(posedge clock);
      flag_is(1'b0);
      level <= idle(pol) ^ (8'h01 << p);
      repeat (6) @(posedge clock);
      flag_is(1'b1);
      chk({31'h0, irq}, 32'h0000_0001);
      wctl({pol, 4'h6});
      flag_is(1'b0);
      chk({31'h0, irq}, 32'h0000_0000);
      wpe(8'h00);
    end
    // edge and level mode: clear refused while a pin is held
    level <= 8'hff;
    wctl(8'h01);
    wpe(8'h03);
    repeat (6) @(posedge clock);
    level <= 8'hfe;
    repeat (6) @(posedge clock);
    flag_is(1'b1);
    chk({31'h0, irq}, 32'h0000_0000);
    wctl(8'h05);
    flag_is(1'b1);
    level <= 8'hff;
    repeat (6) @(posedge clock);
    wctl(8'h15);
    flag_is(1'b0);
    // stop: flag cleared first, pins become level wakeups
    wpe(8'h00);
    level <= 8'hef;
    stop_mode <= 1'b1;
    wpe(8'h10);
    for (int k = 0; k < 4; k++) begin
      level <= k[0] ? 8'hef : 8'hff;
      repeat (3) @(posedge clock);
      chk({31'h0, wake_request}, {31'h0, ~k[0]});
    end
    wpe(8'h01);
    level <= 8'hee;
    repeat (3) @(posedge clock);
    chk({31'h0, wake_request}, 32'h0000_0001);
    flag_is(1'b0);
    level <= 8'hef;
    repeat (3) @(posedge clock);
    stop_mode <= 1'b0;
    // sticky event bits, mask and write-one clear
    rd(keypad_pkg::IRQ_STATUS_ADDR, d);
    chk(d, 32'h0000_0003);
    chk({31'h0, irq}, 32'h0000_0000);
    wr(keypad_pkg::IRQ_MASK_ADDR, 8'h03);
    chk({31'h0, irq}, 32'h0000_0001);
    wr(keypad_pkg::IRQ_STATUS_ADDR, 8'h03);
    chk({31'h0, irq}, 32'h0000_0000);
    end_sim();
  end
endmodule

bind keyboard_edge_level_interrupt keypad_chk chk_i (
  .clock(clock), .rst_n(rst_n), .key_pin(key_pin),
  .stop_mode(stop_mode), .pin_force_input(pin_force_input),
  .wake_request(wake_request), .irq(irq), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rdata(s_axi_rdata));
`default_nettype wire
